// ===== sarc_ctrl.sv
// module: conversion sequencing and serial result readout control
// How it works
// R1: mode latched from select pin at start
// R2: three-wire: convert pin doubles as select
// R3: four-wire: select pin is the chip select
// R4: output bits advance on serial clock falling edges
// R5: conversion timed by own clock only
// R6: after conversion, idle acquisition; result readable
// R7: sample captured at start, held throughout
// R8: select high chip-select mode, low daisy-chain; daisy mode never drives the output
// R9: select fall releases output with msb
// R10: high-z after sixteenth fall or deselect
// R11: result is unsigned straight binary
// R12: host waits maximum conversion before reading
`timescale 1ns/1ps
`default_nettype none
module sarc_ctrl
    import sarc_pkg::*;
#(
    parameter int DATA_W = SARC_DATA_W,
    parameter int CONV_CYC = SARC_CONV_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic convert_start_pin,
    input wire logic ser_in_pin,
    input wire logic ser_clk_pin,
    input wire logic [DATA_W-1:0] sample_code,
    output logic ser_out,
    output logic ser_out_oe,
    output logic converting,
    output logic daisy_mode
);
    // --------------------------------------------------------------
    // reset release
    // --------------------------------------------------------------
    logic [1:0] rst_sh_r; // reset synchroniser
    logic rst_n; // released reset copy
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sh_r <= 2'b00;
        end else begin
            rst_sh_r <= {rst_sh_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sh_r[1];

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [2:0] pins_s; // {sclk, din, convert_start_pin} after two flops
    sarc_sync #(.W(3)) u_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .d({ser_clk_pin, ser_in_pin, convert_start_pin}),
        .q(pins_s)
    );

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    localparam int CW = $clog2(CONV_CYC + 1);
    typedef struct packed {
        sarc_state_t st; // phase
        sarc_mode_t mode; // latched interface mode
        logic cnv_d; // previous convert level
        logic din_d; // previous select level
        logic sck_d; // previous serial clock level
        logic [CW-1:0] cnt; // conversion countdown
        logic [DATA_W-1:0] held; // held sample
        logic [DATA_W-1:0] sh; // output shift word
        logic [4:0] nbit; // falling edges seen in readout
        logic dout; // output bit
        logic oe; // output enable
        logic [1:0] settle; // pin pipeline fill count after reset
    } sarc_s_t;

    sarc_s_t s_r;
    sarc_s_t s_nxt;

    // returns the active-low select for the latched mode
    function automatic logic sel_n(input sarc_mode_t m, input logic cnv,
                                   input logic din);
        // three-wire ties din high, so convert_start_pin acts as select
        sel_n = (m == SARC_MODE_CS3) ? (cnv & din) : din; // [R2] [R3]
    endfunction : sel_n

    logic cnv_rise;
    logic sck_fall;
    logic sel_now;
    logic sel_prev;
    // the pin flops reset low while the idle convert level is high, so
    // convert rising edges are ignored until the pin pipeline has filled after reset
    assign cnv_rise = pins_s[0] & ~s_r.cnv_d & (s_r.settle == 2'b11);
    assign sck_fall = ~pins_s[2] & s_r.sck_d;
    assign sel_now = sel_n(s_r.mode, pins_s[0], pins_s[1]);
    assign sel_prev = sel_n(s_r.mode, s_r.cnv_d, s_r.din_d);

    // --------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.cnv_d = pins_s[0];
        s_nxt.din_d = pins_s[1];
        s_nxt.sck_d = pins_s[2];
        // count up once after reset, then stay full
        s_nxt.settle = (s_r.settle == 2'b11) ? 2'b11
                                              : s_r.settle + 2'b01;
        case (s_r.st)
            SARC_ST_CONV: begin
                // internal clock only; serial clock ignored here [R5]
                if (s_r.cnt == '0) begin
                    s_nxt.st = SARC_ST_ACQ; // [R6]
                    s_nxt.sh = s_r.held; // straight binary [R11]
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            SARC_ST_ACQ, SARC_ST_READ: begin
                if (cnv_rise) begin
                    // mode from select level at start [R1] [R8]
                    s_nxt.mode = pins_s[1] ? SARC_MODE_CS3
                                           : SARC_MODE_DAISY;
                    s_nxt.held = sample_code; // [R7]
                    s_nxt.cnt = CW'(CONV_CYC - 1);
                    s_nxt.st = SARC_ST_CONV;
                    s_nxt.oe = 1'b0;
                    s_nxt.nbit = '0;
                end else if (s_r.st == SARC_ST_ACQ && !sel_now &&
                             sel_prev && s_r.mode == SARC_MODE_CS3) begin
                    // select fall: drive msb [R9]
                    s_nxt.st = SARC_ST_READ;
                    s_nxt.oe = 1'b1;
                    s_nxt.dout = s_r.sh[DATA_W-1];
                    s_nxt.sh = {s_r.sh[DATA_W-2:0], 1'b0};
                    s_nxt.nbit = '0;
                end else if (s_r.st == SARC_ST_READ) begin
                    if (sel_now) begin
                        // deselect ends the frame [R10]
                        s_nxt.oe = 1'b0;
                        s_nxt.st = SARC_ST_ACQ;
                    end else if (sck_fall) begin
                        s_nxt.nbit = s_r.nbit + 1'b1; // [R4]
                        if (s_r.nbit == 5'(DATA_W - 1)) begin
                            s_nxt.oe = 1'b0; // sixteenth fall [R10]
                        end else begin
                            s_nxt.dout = s_r.sh[DATA_W-1]; // [R9]
                            s_nxt.sh = {s_r.sh[DATA_W-2:0], 1'b0};
                        end
                    end
                end
            end
            default: begin
                s_nxt.st = SARC_ST_ACQ;
            end
        endcase
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: SARC_ST_ACQ, mode: SARC_MODE_CS3, cnv_d: 1'b0,
                     din_d: 1'b0, sck_d: 1'b0, cnt: '0,
                     held: SARC_RESULT_RST, sh: SARC_RESULT_RST,
                     nbit: '0, dout: 1'b0, oe: 1'b0, settle: 2'b00};
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign ser_out = s_r.dout;
    assign ser_out_oe = s_r.oe;
    assign converting = s_r.st[1];
    assign daisy_mode = s_r.mode[1];

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // cycles spent in the current conversion; a counter, because the
    // longest legal conversion is far beyond any delay range
    logic [11:0] conv_age_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_age_r <= 12'h000;
        end else if (converting) begin
            conv_age_r <= conv_age_r + 12'h001;
        end else begin
            conv_age_r <= 12'h000;
        end
    end

    sequence start_seen;
        s_r.st != SARC_ST_CONV && cnv_rise;
    endsequence
    a_start_conv: assert property ( // [R5]
        start_seen |=> converting [*8])
        else $error("conversion did not start");
    a_mode_pick: assert property ( // [R8]
        start_seen |=> (daisy_mode == !$past(pins_s[1])))
        else $error("mode not latched from select");
    a_hold_sample: assert property ( // [R7]
        converting && $past(converting) |-> $stable(s_r.held))
        else $error("held sample changed");
    a_conv_end: assert property ( // [R5]
        converting |-> conv_age_r < 12'(SARC_CONV_MAX_CYC))
        else $error("conversion too long");
    a_conv_min: assert property ( // [R5]
        $fell(converting) |->
            $past(conv_age_r) >= 12'(SARC_CONV_MIN_CYC - 1))
        else $error("conversion too short");
    a_quiet_conv: assert property ( // [R10]
        converting |-> !ser_out_oe)
        else $error("output driven during conversion");
    a_no_daisy_out: assert property ( // [R8]
        daisy_mode |-> !ser_out_oe)
        else $error("readout opened in daisy mode");
    a_deselect: assert property ( // [R3]
        s_r.st == SARC_ST_READ && sel_now && !cnv_rise |=> !ser_out_oe)
        else $error("output not released on deselect");
    a_msb_first: assert property ( // [R9]
        $rose(ser_out_oe) |-> ser_out == $past(s_r.sh[DATA_W-1]))
        else $error("msb not presented first");
    a_shift_fall: assert property ( // [R4]
        ser_out_oe && !sck_fall && !sel_now && !cnv_rise
            |=> $stable(ser_out))
        else $error("output moved without clock fall");
endmodule : sarc_ctrl
`default_nettype wire

// ===== sarc_ctrl_bench.sv
// testbench: conversion sequencing and serial readout
`timescale 1ns/1ps
`default_nettype none
module sarc_ctrl_bench;
    import sarc_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] sample_code = 16'h0000;
    logic convert_start_pin, ser_in_pin, ser_clk_pin;
    logic ser_out, ser_out_oe, converting, daisy_mode;
    // line seen by the host: a released output reads as the inverse, so
    // a host that samples outside the frame picks up wrong bits
    logic dout_line;
    assign dout_line = ser_out_oe ? ser_out : ~ser_out;
    int failures = 0;
    int total_checks = 0;
    int conv_cnt = 0;
    int conv_len = 0; // length of the last conversion pulse
    always #2 sys_clk = ~sys_clk;

    sarc_ctrl u_sarc_ctrl (.sys_clk(sys_clk), .arst_n(arst_n),
        .convert_start_pin(convert_start_pin), .ser_in_pin(ser_in_pin),
        .ser_clk_pin(ser_clk_pin), .sample_code(sample_code),
        .ser_out(ser_out), .ser_out_oe(ser_out_oe),
        .converting(converting), .daisy_mode(daisy_mode));
    sarc_host u_sarc_host (.sys_clk(sys_clk),
        .convert_start_pin(convert_start_pin), .ser_in_pin(ser_in_pin),
        .ser_clk_pin(ser_clk_pin), .ser_out(dout_line));

    // measures the busy pulse so its length can be judged
    always @(posedge sys_clk) begin
        if (converting === 1'b1) begin
            conv_cnt <= conv_cnt + 1;
        end else if (conv_cnt != 0) begin
            conv_len <= conv_cnt;
            conv_cnt <= 0;
        end
    end
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    localparam logic [15:0] CONV_CYC_T = 16'(SARC_CONV_CYC);
    // least spacing of two conversion starts, in system clocks
    localparam int GAP_CYC = SARC_TCYC_NS * 1000 / SARC_CLK_PS;
    // full read in chip-select mode; input changes mid-conversion
    task automatic run_read(input logic wire4, input logic [15:0] code);
        logic [15:0] w;
        @(negedge sys_clk) sample_code <= code;
        fork
            u_sarc_host.arm(1'b1);
            begin
                repeat (20) @(negedge sys_clk);
                sample_code <= ~code; // held sample must not follow
            end
        join
        check("mode", {15'd0, daisy_mode}, 16'h0000);
        check("busy", {15'd0, converting}, 16'h0000);
        check("conv", conv_len[15:0], CONV_CYC_T);
        u_sarc_host.select(wire4, 1'b0);
        repeat (4) @(negedge sys_clk);
        check("oe", {15'd0, ser_out_oe}, 16'h0001);
        check("msb", {15'd0, ser_out}, {15'd0, code[15]});
        u_sarc_host.shift(16, w);
        check("word", w, code);
        repeat (4) @(negedge sys_clk);
        check("oe16", {15'd0, ser_out_oe}, 16'h0000);
        u_sarc_host.select(wire4, 1'b1);
        // a three-wire deselect is itself a start: keep the start spacing
        if (!wire4) begin
            repeat (GAP_CYC) @(negedge sys_clk);
        end
    endtask : run_read
    // deselect after half a word: output must release early
    task automatic run_abort(input logic wire4);
        logic [15:0] w;
        @(negedge sys_clk) sample_code <= 16'hC3A5;
        u_sarc_host.arm(1'b1);
        u_sarc_host.select(wire4, 1'b0);
        u_sarc_host.shift(8, w);
        check("half", w, 16'h00C3);
        u_sarc_host.select(wire4, 1'b1);
        repeat (4) @(negedge sys_clk);
        check("oe_cut", {15'd0, ser_out_oe}, 16'h0000);
        repeat (wire4 ? 200 : GAP_CYC) @(negedge sys_clk);
    endtask : run_abort
    // select low at start: chain mode, output never driven here
    task automatic run_daisy();
        logic [15:0] w;
        u_sarc_host.arm(1'b0);
        check("daisy", {15'd0, daisy_mode}, 16'h0001);
        u_sarc_host.shift(4, w);
        check("oe_dc", {15'd0, ser_out_oe}, 16'h0000);
        u_sarc_host.select(1'b1, 1'b1);
        repeat (200) @(negedge sys_clk);
    endtask : run_daisy
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge sys_clk);
        arst_n <= 1'b1;
        repeat (10) @(negedge sys_clk);
        run_read(1'b1, 16'hA5C3);
        run_read(1'b0, 16'h0000);
        run_read(1'b1, 16'hFFFF);
        run_abort(1'b1);
        run_abort(1'b0);
        run_daisy();
        run_read(1'b0, 16'h8001);
        give_verdict();
    end
    // seven frames and three start gaps, about 25000 cycles; a hang fails
    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end
endmodule : sarc_ctrl_bench
`default_nettype wire

// ===== sarc_host.sv
// host model: drives start, select and serial clock, shifts the result in
`timescale 1ns/1ps
`default_nettype none
module sarc_host (
    input wire logic sys_clk,
    output logic convert_start_pin,
    output logic ser_in_pin,
    output logic ser_clk_pin,
    input wire logic ser_out
);
    // idle: start high, select high, serial clock parked low
    initial begin
        convert_start_pin = 1'b1;
        ser_in_pin = 1'b1;
        ser_clk_pin = 1'b0;
    end
    // ------------------------------------------------------------
    // host tasks, all changes just after a falling system clock edge
    // ------------------------------------------------------------
    // set mode level first, then give a fresh start rising edge
    task automatic arm(input logic din);
        @(negedge sys_clk) ser_in_pin <= din;
        @(negedge sys_clk) convert_start_pin <= 1'b0;
        repeat (6) @(negedge sys_clk);
        convert_start_pin <= 1'b1;
        // no serial clock and a full worst-case wait: no done flag
        repeat (2200) @(negedge sys_clk);
    endtask : arm
    // select level: select pin in four-wire, start pin in three-wire
    task automatic select(input logic wire4, input logic lvl);
        @(negedge sys_clk);
        if (wire4) begin
            ser_in_pin <= lvl;
        end else begin
            convert_start_pin <= lvl;
        end
    endtask : select
    // 80 ns serial clock, sampled on the rise, also clocked in daisy mode with no frame open
    task automatic shift(input int n, output logic [15:0] w);
        w = 16'h0000;
        for (int i = 0; i < n; i++) begin
            repeat (10) @(negedge sys_clk);
            ser_clk_pin <= 1'b1;
            w = {w[14:0], ser_out};
            repeat (10) @(negedge sys_clk);
            ser_clk_pin <= 1'b0;
        end
    endtask : shift
endmodule : sarc_host
`default_nettype wire

// ===== sarc_pkg.sv
// package: constants and types for the converter sequencing and readout block
package sarc_pkg;
    // conversion word width
    localparam int SARC_DATA_W = 16;
    // system clock period in picoseconds (250 MHz)
    localparam int SARC_CLK_PS = 4000;
    // conversion time bounds in ns
    localparam int SARC_TCONV_MIN_NS = 500;
    localparam int SARC_TCONV_MAX_NS = 8800;
    // acquisition and cycle time in ns (host obligations)
    localparam int SARC_TACQ_NS = 1200;
    localparam int SARC_TCYC_NS = 10000;
    // least time rounds up, longest time rounds down
    localparam int SARC_CONV_MIN_CYC =
        (SARC_TCONV_MIN_NS * 1000 + SARC_CLK_PS - 1) / SARC_CLK_PS;
    localparam int SARC_CONV_MAX_CYC =
        (SARC_TCONV_MAX_NS * 1000) / SARC_CLK_PS;
    // default conversion length used by the block
    localparam int SARC_CONV_CYC = SARC_CONV_MIN_CYC;
    // reset value of the result word
    localparam logic [15:0] SARC_RESULT_RST = 16'h0000;

    // interface mode selected at convert start
    typedef enum logic [1:0] {
        SARC_MODE_CS3 = 2'b01,
        SARC_MODE_DAISY = 2'b10
    } sarc_mode_t;

    // top-level phases, one-hot
    typedef enum logic [2:0] {
        SARC_ST_ACQ = 3'b001,
        SARC_ST_CONV = 3'b010,
        SARC_ST_READ = 3'b100
    } sarc_state_t;
endpackage : sarc_pkg

// ===== sarc_sync.sv
// module: two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module sarc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // first stage feeds only the second stage
    logic [W-1:0] meta_r;

    // --------------------------------------------------------------
    // two-stage capture
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sarc_sync
`default_nettype wire
